// [logic/audio_serial_consts.vh]
// Register offsets, field positions, reset values and build codes for the
// audio serial FIFO and DMA control block.
// Assumes a 12-bit byte address on the block's register port.
//
// Behaviour
// - Mask bit one blocks receive-available interrupt.
// - Reading receive overrun register clears the flag.
// - Reading transmit overrun register clears the flag.
// - Receive available raised at programmed fill level.
// - Transmit empty raised at programmed level.
// - Writing one to receive flush empties FIFO.
// - Writing one to transmit flush empties FIFO.
// - Receive DMA reads step left, right, repeatedly.
// - Receive pointer reset returns to first channel.
// - Transmit DMA port steps through pairs.
// - Transmit pointer reset returns to first channel.
// - Build register reports receive word size code.
// - Second build register reports transmit sizes.
// - Version register is read only.
// - Receive available status shows trigger reached.
// - Transmit overrun status shows full write.
`ifndef AUDIO_SERIAL_CONSTS_VH
`define AUDIO_SERIAL_CONSTS_VH

`define OFF_STATUS 12'h038
`define OFF_MASK 12'h03C
`define OFF_RX_OVR_CLR 12'h040
`define OFF_TX_OVR_CLR 12'h044
`define OFF_RX_TRIG 12'h048
`define OFF_TX_TRIG 12'h04C
`define OFF_RX_FLUSH 12'h050
`define OFF_TX_FLUSH 12'h054
`define OFF_RX_DMA 12'h1C0
`define OFF_RX_DMA_RST 12'h1C4
`define OFF_TX_DMA 12'h1C8
`define OFF_TX_DMA_RST 12'h1CC
`define OFF_BUILD_RX 12'h1F0
`define OFF_BUILD_GEN 12'h1F4
`define OFF_VERSION 12'h1F8

`define BIT_RX_AVAIL 0
`define BIT_RX_OVR 1
`define BIT_TX_EMPTY 4
`define BIT_TX_OVR 5

`define RST_MASK 6'h33
`define RST_TRIG 4'h3
`define RST_OVR 1'b1

`define POS_RX_WS0 0
`define POS_TX_WS0 16
`define POS_TX_CHANS 9
`define POS_RX_CHANS 7
`define POS_RX_BLOCK 6
`define POS_TX_BLOCK 5
`define POS_MODE_EN 4
`define POS_FIFO_DEPTH 2
`define POS_BUS_WIDTH 0
`define CODE_BUS_WIDTH_32 2'h2

`endif

// [logic/audio_serial_fifo_dma_ctrl.v]
// Channel 0 FIFO, trigger, flush and block DMA control of the audio serial unit.
// Assumes the framing logic and register port run on clk_i; the register port
// gives one-cycle read and write strobes and expects read data one cycle later.
`timescale 1ns/1ps
`include "audio_serial_consts.vh"

module audio_serial_fifo_dma_ctrl #(
    parameter DW = 32,
    parameter AW = 4,
    parameter [1:0] FIFO_DEPTH_CODE = 2'h3,
    parameter [2:0] RX_WORD_SIZE = 3'h1,
    parameter [2:0] TX_WORD_SIZE = 3'h1,
    // Arbitrary release value.
    parameter [31:0] COMP_VERSION = 32'h0000_0001
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire [11:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    output reg reg_rvalid_o,
    input wire rx_enable_i,
    input wire tx_enable_i,
    input wire rx_sample_valid_i,
    input wire [DW-1:0] rx_left_i,
    input wire [DW-1:0] rx_right_i,
    input wire tx_sample_ready_i,
    output reg tx_sample_valid_o,
    output reg [DW-1:0] tx_left_o,
    output reg [DW-1:0] tx_right_o,
    output reg irq_o
);

    // The depth code in the build register must be kept in step with AW.
    localparam DEPTH = 1 << AW;

    reg [DW-1:0] rx_left_mem [0:DEPTH-1];
    reg [DW-1:0] rx_right_mem [0:DEPTH-1];
    reg [DW-1:0] tx_left_mem [0:DEPTH-1];
    reg [DW-1:0] tx_right_mem [0:DEPTH-1];
    reg [AW:0] rx_wr_ptr;
    reg [AW:0] rx_rd_ptr;
    reg [AW:0] tx_wr_ptr;
    reg [AW:0] tx_rd_ptr;
    reg [5:0] irq_mask;
    reg [3:0] rx_trigger_level_field;
    reg [3:0] tx_empty_threshold_field;
    reg rx_ovr;
    reg tx_ovr;
    reg rx_dma_right;
    reg tx_dma_right;
    reg [DW-1:0] tx_left_hold;
    reg [31:0] next_rdata;
    reg [5:0] status;
    reg [31:0] build_rx;
    reg [31:0] build_gen;

    // The pointers carry one extra bit so that full and empty differ.
    wire [AW:0] rx_level = rx_wr_ptr - rx_rd_ptr;
    wire [AW:0] tx_level = tx_wr_ptr - tx_rd_ptr;
    wire rx_full = rx_level[AW];
    wire rx_empty = (rx_level == {(AW+1){1'b0}});
    wire tx_full = tx_level[AW];
    wire tx_empty = (tx_level == {(AW+1){1'b0}});

    // Decodes compare the whole byte address, so aliases read as unmapped.
    wire wr_hit_mask = reg_wr_i && (reg_addr_i == `OFF_MASK);
    wire wr_rx_trig = reg_wr_i && (reg_addr_i == `OFF_RX_TRIG);
    wire wr_tx_trig = reg_wr_i && (reg_addr_i == `OFF_TX_TRIG);
    wire rx_flush = reg_wr_i && (reg_addr_i == `OFF_RX_FLUSH) && reg_wdata_i[0];
    wire tx_flush = reg_wr_i && (reg_addr_i == `OFF_TX_FLUSH) && reg_wdata_i[0];
    wire rx_dma_rst = reg_wr_i && (reg_addr_i == `OFF_RX_DMA_RST) && reg_wdata_i[0];
    wire tx_dma_rst = reg_wr_i && (reg_addr_i == `OFF_TX_DMA_RST) && reg_wdata_i[0];
    wire rd_rx_ovr = reg_rd_i && (reg_addr_i == `OFF_RX_OVR_CLR);
    wire rd_tx_ovr = reg_rd_i && (reg_addr_i == `OFF_TX_OVR_CLR);
    wire rd_rx_dma = reg_rd_i && (reg_addr_i == `OFF_RX_DMA) && rx_enable_i;
    wire wr_tx_dma = reg_wr_i && (reg_addr_i == `OFF_TX_DMA) && tx_enable_i;

    // A read of the right half pops the pair; an empty FIFO returns zero and
    // does not advance, so a starved DMA does not lose its place in the pair.
    wire rx_pop = rd_rx_dma && rx_dma_right && !rx_empty;
    wire rx_push = rx_sample_valid_i && rx_enable_i && !rx_full;
    wire rx_ovr_set = rx_sample_valid_i && rx_enable_i && rx_full;
    wire tx_push = wr_tx_dma && tx_dma_right && !tx_full;
    wire tx_ovr_set = wr_tx_dma && tx_dma_right && tx_full;
    wire tx_pop = tx_sample_ready_i && tx_enable_i && !tx_empty;

    // The trigger fields are four bits and the fill count AW+1 bits, so the
    // fields are widened to the count; this limits AW to at least three.
    wire [AW:0] rx_trig_wide = {{(AW-3){1'b0}}, rx_trigger_level_field};
    wire [AW:0] tx_thr_wide = {{(AW-3){1'b0}}, tx_empty_threshold_field};
    wire rx_avail = (rx_level >= rx_trig_wide);
    wire tx_at_thr = (tx_level <= tx_thr_wide);

    // Status bit positions are shared with the mask so one AND gives the sources.
    always @* begin
        status = 6'h00;
        status[`BIT_RX_AVAIL] = rx_avail;
        status[`BIT_RX_OVR] = rx_ovr;
        status[`BIT_TX_EMPTY] = tx_at_thr;
        status[`BIT_TX_OVR] = tx_ovr;
    end

    // One channel per direction, so both channel-count fields hold the code for one.
    always @* begin
        build_rx = 32'h0000_0000;
        build_rx[`POS_RX_WS0 +: 3] = RX_WORD_SIZE;
        build_gen = 32'h0000_0000;
        build_gen[`POS_TX_WS0 +: 3] = TX_WORD_SIZE;
        build_gen[`POS_TX_CHANS +: 2] = 2'h0;
        build_gen[`POS_RX_CHANS +: 2] = 2'h0;
        build_gen[`POS_RX_BLOCK] = 1'b1;
        build_gen[`POS_TX_BLOCK] = 1'b1;
        build_gen[`POS_MODE_EN] = 1'b1;
        build_gen[`POS_FIFO_DEPTH +: 2] = FIFO_DEPTH_CODE;
        build_gen[`POS_BUS_WIDTH +: 2] = `CODE_BUS_WIDTH_32;
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        case (reg_addr_i)
            `OFF_STATUS: begin
                next_rdata = {26'h0, status};
            end
            `OFF_MASK: begin
                next_rdata = {26'h0, irq_mask};
            end
            `OFF_RX_OVR_CLR: begin
                next_rdata = {31'h0, rx_ovr};
            end
            `OFF_TX_OVR_CLR: begin
                next_rdata = {31'h0, tx_ovr};
            end
            `OFF_RX_TRIG: begin
                next_rdata = {28'h0, rx_trigger_level_field};
            end
            `OFF_TX_TRIG: begin
                next_rdata = {28'h0, tx_empty_threshold_field};
            end
            `OFF_RX_DMA: begin
                // A disabled or empty receive side reads as zero with no side effect.
                if (rx_enable_i && !rx_empty) begin
                    if (rx_dma_right) begin
                        next_rdata = rx_right_mem[rx_rd_ptr[AW-1:0]];
                    end else begin
                        next_rdata = rx_left_mem[rx_rd_ptr[AW-1:0]];
                    end
                end
            end
            `OFF_BUILD_RX: begin
                next_rdata = build_rx;
            end
            `OFF_BUILD_GEN: begin
                next_rdata = build_gen;
            end
            `OFF_VERSION: begin
                next_rdata = COMP_VERSION;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data is zero outside the answer cycle so a stale word never looks fresh.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 32'h0000_0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
        end
    end

    // Mask bits with no status source stay zero, as the reserved bits read.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_mask <= `RST_MASK;
            rx_trigger_level_field <= `RST_TRIG;
            tx_empty_threshold_field <= `RST_TRIG;
        end else begin
            if (wr_hit_mask) begin
                irq_mask <= reg_wdata_i[5:0] & `RST_MASK;
            end
            if (wr_rx_trig) begin
                rx_trigger_level_field <= reg_wdata_i[3:0];
            end
            if (wr_tx_trig) begin
                tx_empty_threshold_field <= reg_wdata_i[3:0];
            end
        end
    end

    // The overrun flags are sticky; a new overrun in the clearing read's cycle
    // keeps the flag set so the event is not lost.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_ovr <= `RST_OVR;
            tx_ovr <= `RST_OVR;
        end else begin
            rx_ovr <= rx_ovr_set | (rx_ovr & ~rd_rx_ovr);
            tx_ovr <= tx_ovr_set | (tx_ovr & ~rd_tx_ovr);
        end
    end

    // Flushing while the channel runs could race a framing push; software is
    // expected to disable the channel first, and the flush simply wins.
    // A flush also returns the DMA port to the left word of the pair.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_wr_ptr <= {(AW+1){1'b0}};
            rx_rd_ptr <= {(AW+1){1'b0}};
            rx_dma_right <= 1'b0;
        end else begin
            if (rx_flush) begin
                rx_wr_ptr <= {(AW+1){1'b0}};
                rx_rd_ptr <= {(AW+1){1'b0}};
            end else begin
                if (rx_push) begin
                    rx_wr_ptr <= rx_wr_ptr + 1'b1;
                end
                if (rx_pop) begin
                    rx_rd_ptr <= rx_rd_ptr + 1'b1;
                end
            end
            if (rx_dma_rst || rx_flush) begin
                rx_dma_right <= 1'b0;
            end else if (rd_rx_dma && !rx_empty) begin
                rx_dma_right <= ~rx_dma_right;
            end
        end
    end

    // The sample stores need no reset; the pointers alone say which words are live.
    always @(posedge clk_i) begin
        if (rx_push) begin
            rx_left_mem[rx_wr_ptr[AW-1:0]] <= rx_left_i;
            rx_right_mem[rx_wr_ptr[AW-1:0]] <= rx_right_i;
        end
        if (tx_push) begin
            tx_left_mem[tx_wr_ptr[AW-1:0]] <= tx_left_hold;
            tx_right_mem[tx_wr_ptr[AW-1:0]] <= reg_wdata_i[DW-1:0];
        end
    end

    // A pointer reset discards a held left word; the next write starts a new pair.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_wr_ptr <= {(AW+1){1'b0}};
            tx_rd_ptr <= {(AW+1){1'b0}};
            tx_dma_right <= 1'b0;
            tx_left_hold <= {DW{1'b0}};
        end else begin
            if (tx_flush) begin
                tx_wr_ptr <= {(AW+1){1'b0}};
                tx_rd_ptr <= {(AW+1){1'b0}};
            end else begin
                if (tx_push) begin
                    tx_wr_ptr <= tx_wr_ptr + 1'b1;
                end
                if (tx_pop) begin
                    tx_rd_ptr <= tx_rd_ptr + 1'b1;
                end
            end
            if (wr_tx_dma && !tx_dma_right) begin
                tx_left_hold <= reg_wdata_i[DW-1:0];
            end
            if (tx_dma_rst || tx_flush) begin
                tx_dma_right <= 1'b0;
            end else if (wr_tx_dma) begin
                tx_dma_right <= ~tx_dma_right;
            end
        end
    end

    // The pair lines change only on a pop and then hold, so the framing logic
    // may take them at any later point of its frame.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_sample_valid_o <= 1'b0;
            tx_left_o <= {DW{1'b0}};
            tx_right_o <= {DW{1'b0}};
        end else begin
            tx_sample_valid_o <= tx_pop && !tx_flush;
            if (tx_pop && !tx_flush) begin
                tx_left_o <= tx_left_mem[tx_rd_ptr[AW-1:0]];
                tx_right_o <= tx_right_mem[tx_rd_ptr[AW-1:0]];
            end
        end
    end

    // Registered so the pin cannot glitch while status settles, at one cycle of delay.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & ~irq_mask);
        end
    end

endmodule

// [test/codec_model.sv]
// Behavioural stand-in for the framing logic that faces the external codec.
// Assumes its tasks are called just after a rising edge of clk_i.
`timescale 1ns/1ps
module codec_model (
    input wire clk_i,
    output logic valid_o,
    output logic ready_o,
    output logic [31:0] left_o,
    output logic [31:0] right_o
);
    int seq = 0;
    initial begin
        valid_o = 1'b0;
        ready_o = 1'b0;
        left_o = 32'h0;
        right_o = 32'h0;
    end
    // Between pairs the data lines show the inverse, so a stale word cannot pass for new.
    task send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            #1;
            valid_o = 1'b1;
            left_o = 32'hA000_0000 + seq;
            right_o = 32'hB000_0000 + seq;
            seq++;
            @(posedge clk_i);
            #1;
            valid_o = 1'b0;
            left_o = ~left_o;
            right_o = ~right_o;
        end
    endtask
    task pull;
        @(posedge clk_i);
        #1;
        ready_o = 1'b1;
        @(posedge clk_i);
        #1;
        ready_o = 1'b0;
    endtask
endmodule

// [test/fifo_dma_checker.sv]
// Concurrent checks on the register port and transmit stream of the FIFO/DMA block.
// Assumes one clock domain and that the block's build parameters are handed on by bind.
`timescale 1ns/1ps
module fifo_dma_checker #(
    parameter [1:0] FIFO_DEPTH_CODE = 2'h3,
    parameter [2:0] RX_WORD_SIZE = 3'h1,
    parameter [2:0] TX_WORD_SIZE = 3'h1,
    parameter [31:0] COMP_VERSION = 32'h0000_0001
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire [11:0] reg_addr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire reg_rvalid_o,
    input wire rx_sample_valid_i,
    input wire tx_enable_i,
    input wire tx_sample_ready_i,
    input wire tx_sample_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire rd_rx_ovr = reg_rd_i && reg_addr_i == 12'h040 && !rx_sample_valid_i;
    wire rd_tx_ovr = reg_rd_i && reg_addr_i == 12'h044;
    rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
    idle_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0)
        else $error("read data outside answer");
    rx_clear_a: assert property (rd_rx_ovr ##1 rd_rx_ovr |=> reg_rdata_o == 32'h0)
        else $error("rx overrun flag survived read");
    tx_clear_a: assert property (rd_tx_ovr ##1 rd_tx_ovr |=> reg_rdata_o == 32'h0)
        else $error("tx overrun flag survived read");
    rx_sizes_a: assert property (reg_rd_i && reg_addr_i == 12'h1F0
        |=> reg_rdata_o == {29'h0, RX_WORD_SIZE}) else $error("rx size code wrong");
    build_general_a: assert property (reg_rd_i && reg_addr_i == 12'h1F4
        |=> reg_rdata_o == {13'h0, TX_WORD_SIZE, 9'h0, 3'h7, FIFO_DEPTH_CODE, 2'h2})
        else $error("general build value wrong");
    version_fixed_a: assert property (reg_rd_i && reg_addr_i == 12'h1F8
        |=> reg_rdata_o == COMP_VERSION) else $error("version value wrong");
    tx_pop_a: assert property (tx_sample_valid_o
        |-> $past(tx_sample_ready_i && tx_enable_i)) else $error("tx pair without request");
    tx_disabled_a: assert property (!tx_enable_i |=> !tx_sample_valid_o)
        else $error("disabled channel popped");
endmodule
bind audio_serial_fifo_dma_ctrl fifo_dma_checker #(.FIFO_DEPTH_CODE(FIFO_DEPTH_CODE),
    .RX_WORD_SIZE(RX_WORD_SIZE), .TX_WORD_SIZE(TX_WORD_SIZE), .COMP_VERSION(COMP_VERSION))
    fifo_dma_checker_i (.clk_i, .rst_b_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .rx_sample_valid_i, .tx_enable_i, .tx_sample_ready_i, .tx_sample_valid_o);

// [test/testbench.sv]
// Self-checking bench for the FIFO/DMA control block and its codec-side model.
// Assumes the default build parameters and a 250 MHz clock.
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
    row_t rows [12];
    logic clk = 1'b0, rst_b = 1'b0, wr_s = 1'b0, rd_s = 1'b0, rx_en = 1'b0, tx_en = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wd = 32'h0, rdata, tl, tr, ml, mr;
    logic [31:0] q [2];
    logic tv, irq, mv, mrd;
    int miscompares = 0, check_count = 0, cyc = 0;
    always #2 clk = ~clk;
    audio_serial_fifo_dma_ctrl audio_serial_fifo_dma_ctrl_i (.clk_i(clk), .rst_b_i(rst_b),
        .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wd),
        .reg_rdata_o(rdata), .reg_rvalid_o(), .rx_enable_i(rx_en), .tx_enable_i(tx_en),
        .rx_sample_valid_i(mv), .rx_left_i(ml), .rx_right_i(mr), .tx_sample_ready_i(mrd),
        .tx_sample_valid_o(tv), .tx_left_o(tl), .tx_right_o(tr), .irq_o(irq));
    codec_model codec_model_i (.clk_i(clk), .valid_o(mv), .ready_o(mrd), .left_o(ml),
        .right_o(mr));
    task conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            conclude;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        wr_s = 1'b1;
        addr = a;
        wd = d;
        @(posedge clk);
        #1;
        wr_s = 1'b0;
    endtask
    // Reads of n back to back; the strobe stays high so read side effects chain.
    task rd(input logic [11:0] a, input int n);
        @(posedge clk);
        #1;
        rd_s = 1'b1;
        addr = a;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (i == n - 1)
                rd_s = 1'b0;
            q[i] = rdata;
        end
    endtask
    initial begin
        rows[0] = '{12'h038, 1'b0, 32'h0, 32'h32};
        rows[1] = '{12'h03C, 1'b0, 32'h0, 32'h33};
        rows[2] = '{12'h040, 1'b0, 32'h0, 32'h1};
        rows[3] = '{12'h040, 1'b0, 32'h0, 32'h0};
        rows[4] = '{12'h044, 1'b0, 32'h0, 32'h1};
        rows[5] = '{12'h048, 1'b1, 32'h5, 32'h5};
        rows[6] = '{12'h04C, 1'b1, 32'h5, 32'h5};
        rows[7] = '{12'h1F0, 1'b0, 32'h0, 32'h1};
        rows[8] = '{12'h1F4, 1'b0, 32'h0, 32'h0001_007E};
        rows[9] = '{12'h1F8, 1'b1, 32'hFFFF_FFFF, 32'h1};
        rows[10] = '{12'h100, 1'b1, 32'h5, 32'h0};
        rows[11] = '{12'h054, 1'b0, 32'h0, 32'h0};
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        for (int i = 0; i < 12; i++) begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, 1);
            chk(q[0], rows[i].e);
        end
        $display("test registers done");
        wr(12'h048, 32'h2);
        wr(12'h03C, 32'h3E);
        rx_en = 1'b1;
        codec_model_i.send(1);
        rd(12'h038, 1);
        chk(q[0], 32'h10);
        chk({31'h0, irq}, 32'h0);
        codec_model_i.send(1);
        rd(12'h038, 1);
        chk(q[0], 32'h11);
        chk({31'h0, irq}, 32'h1);
        wr(12'h03C, 32'h3F);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        rd(12'h1C0, 2);
        chk(q[0], 32'hA000_0000);
        chk(q[1], 32'hB000_0000);
        rd(12'h1C0, 1);
        wr(12'h1C4, 32'h1);
        rd(12'h1C0, 2);
        chk(q[0], 32'hA000_0001);
        chk(q[1], 32'hB000_0001);
        rd(12'h1C0, 1);
        chk(q[0], 32'h0);
        codec_model_i.send(3);
        rx_en = 1'b0;
        wr(12'h050, 32'h1);
        rx_en = 1'b1;
        rd(12'h038, 1);
        chk(q[0], 32'h10);
        rd(12'h1C0, 1);
        chk(q[0], 32'h0);
        $display("test receive done");
        tx_en = 1'b1;
        wr(12'h1C8, 32'hC0);
        wr(12'h1C8, 32'hC1);
        wr(12'h1C8, 32'hC2);
        wr(12'h1CC, 32'h1);
        wr(12'h1C8, 32'hD0);
        wr(12'h1C8, 32'hD1);
        codec_model_i.pull;
        chk({31'h0, tv}, 32'h1);
        chk(tl, 32'hC0);
        chk(tr, 32'hC1);
        codec_model_i.pull;
        chk(tl, 32'hD0);
        chk(tr, 32'hD1);
        for (int k = 0; k < 17; k++) begin
            wr(12'h1C8, k);
            wr(12'h1C8, k);
        end
        rd(12'h038, 1);
        chk(q[0], 32'h20);
        rd(12'h044, 2);
        chk(q[0], 32'h1);
        chk(q[1], 32'h0);
        tx_en = 1'b0;
        wr(12'h054, 32'h1);
        tx_en = 1'b1;
        rd(12'h038, 1);
        chk(q[0], 32'h10);
        codec_model_i.pull;
        chk({31'h0, tv}, 32'h0);
        $display("test transmit done");
        codec_model_i.send(17);
        rd(12'h040, 2);
        chk(q[0], 32'h1);
        chk(q[1], 32'h0);
        $display("test receive overrun done");
        rst_b = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        rd(12'h048, 1);
        chk(q[0], 32'h3);
        $display("test reset done");
        conclude;
    end
endmodule
